// ### dfp_pkg.sv
package dfp_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_FEAT = 8'h08;
  localparam logic [7:0] A_TMR = 8'h0C;
  localparam int CMD_OP = 0;
  localparam int CMD_FEA = 8;
  localparam int CMD_COUNT = 16;
  localparam int ST_CLR_IRQ = 2;
  localparam int ST_SRST = 8;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] C_SETF = 8'hEF;
  localparam logic [7:0] C_MAX = 8'hF9;
  localparam logic [7:0] C_MAXX = 8'h37;
  localparam logic [7:0] C_MULT = 8'hC6;
  localparam logic [7:0] C_SLEEP = 8'hE6;
  localparam logic [7:0] C_STBY = 8'hE2;
  localparam logic [7:0] C_SMART = 8'hB0;
  // Feature codes
  localparam logic [7:0] F_WC_ON = 8'h02;
  localparam logic [7:0] F_XFER = 8'h03;
  localparam logic [7:0] F_PUIS_ON = 8'h06;
  localparam logic [7:0] F_SPINUP = 8'h07;
  localparam logic [7:0] F_LNK_ON = 8'h10;
  localparam logic [7:0] F_AAM_ON = 8'h42;
  localparam logic [7:0] F_RLA_OFF = 8'h55;
  localparam logic [7:0] F_WC_OFF = 8'h82;
  localparam logic [7:0] F_PUIS_OFF = 8'h86;
  localparam logic [7:0] F_LNK_OFF = 8'h90;
  localparam logic [7:0] F_RLA_ON = 8'hAA;
  localparam logic [7:0] F_AAM_OFF = 8'hC2;
  // Transfer types, bits 7:3
  localparam logic [4:0] X_PIO = 5'h00;
  localparam logic [4:0] X_PIOFC = 5'h01;
  localparam logic [4:0] X_MDMA = 5'h04;
  localparam logic [4:0] X_UDMA = 5'h08;
  // SMART subcommands
  localparam logic [7:0] S_RDATA = 8'hD0;
  localparam logic [7:0] S_ASAVE = 8'hD2;
  localparam logic [7:0] S_OFFL = 8'hD4;
  localparam logic [7:0] S_RLOG = 8'hD5;
  localparam logic [7:0] S_WLOG = 8'hD6;
  localparam logic [7:0] S_ENA = 8'hD8;
  localparam logic [7:0] S_DIS = 8'hD9;
  localparam logic [7:0] S_STAT = 8'hDA;
  localparam logic [7:0] S_AS_ON = 8'hF1;
  // ****************************************
  // Timing and resets
  // ****************************************
  localparam int CLK_NS = 4;
  localparam int SPIN_DOWN_NS = 1000;
  localparam int SPIN_DOWN_CYC = (SPIN_DOWN_NS + CLK_NS - 1) / CLK_NS;
  localparam int STBY_UNIT_NS = 5000000;
  localparam int STBY_UNIT_CYC = STBY_UNIT_NS / CLK_NS;
  localparam logic [7:0] RST_XFER = 8'h00;
  localparam logic [4:0] RST_MULT = 5'h00;
  typedef enum logic [1:0] {
    DFP_IDLE = 2'b00,
    DFP_EXEC = 2'b01,
    DFP_SPIN = 2'b10,
    DFP_SLEEP = 2'b11
  } dfp_state_t;
endpackage : dfp_pkg

// ### dfp_cmd.sv
`timescale 1ns/1ns
// Operation
// - Set features checks feature, clears busy, interrupts
// - Bad feature code aborts, nothing applied
// - 55h look-ahead off, AAh on
// - 06h/86h standby power-up, 07h spin up
// - 10h/90h link feature by sector count
// - 42h/C2h acoustic; obsolete, vendor codes abort
// - Sector count: type bits 7:3, mode 2:0
// - Decode PIO, PIO flow, multiword, ultra types
// - Ultra DMA setting leaves link rate alone
// - Max-address subcommands 1-4; others abort
// - Set multiple accepts 2,4,8,16, enables them
// - Bad block count aborts, disables multiple
// - Hard reset disables multiple; soft keeps it
// - Sleep spins down, then busy clear, interrupt
// - Only a software or hard reset leaves sleep
// - Sleep while stopped skips spin-down
// - Standby clears busy, interrupts at once
// - Non-zero count arms standby timer
// - SMART dispatches on feature value
// - SMART disable stops all, state persistent
// - SMART off: all but enable abort
// - Auto-save: 0 off, F1h on
module dfp_cmd
#(
  parameter int STBY_UNIT = dfp_pkg::STBY_UNIT_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        nv_smart_in,
  input  wire logic        nv_asave_in,
  output logic             nv_smart,
  output logic             nv_asave,
  output logic             busy_flag,
  output logic             host_interrupt_request,
  output logic             pio_flow_ready,
  output logic             link_active
);
  import dfp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    dfp_state_t  fsm;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        loaded;
    logic [7:0]  op;
    logic [7:0]  fea;
    logic [7:0]  sc;
    logic        busy;
    logic        irq;
    logic        err;
    logic        wcache;
    logic        rla;
    logic        puis;
    logic        aam;
    logic [2:0]  lnk;
    logic [7:0]  xfer;
    logic [4:0]  mult;
    logic        mult_en;
    logic        spinning;
    logic        standby;
    logic        tmr_en;
    logic [7:0]  tmr_sc;
    logic [31:0] cnt;
    logic        hpa_frz;
    logic        smart;
    logic        asave;
    logic        flow_rdy;
    logic        awake;
  } dfp_reg_t;

  dfp_reg_t r;
  dfp_reg_t next_r;
  logic     acc;
  logic     bad;

  assign acc = psel & penable & r.pready;

  // ****************************************
  // Next state
  // ****************************************
  // Commands are accepted only when idle; a busy device ignores new ones
  always_comb
  begin
    next_r = r;
    bad = 1'b0;
    next_r.pready = psel & penable & ~r.pready;
    next_r.pslverr = 1'b0;
    // Non-volatile SMART state is caught once after reset release
    if (!r.loaded)
    begin
      next_r.loaded = 1'b1;
      next_r.smart = nv_smart_in;
      next_r.asave = nv_asave_in;
    end
    // Read data staged during the wait cycle
    case (paddr)
      A_CMD: next_r.prdata = {8'h00, r.sc, r.fea, r.op};
      A_STAT: next_r.prdata = {26'h000_0000, r.spinning, r.standby,
                               r.fsm == DFP_SLEEP, r.irq, r.err, r.busy};
      A_FEAT: next_r.prdata = {r.xfer, 9'h000, r.mult, r.asave, r.smart,
                               r.mult_en, r.lnk, r.aam, r.puis, r.rla, r.wcache};
      A_TMR: next_r.prdata = {r.tmr_en, 7'h00, r.tmr_sc, 16'h0000};
      default:
      begin
        next_r.prdata = 32'h0000_0000;
        next_r.pslverr = psel & penable & ~r.pready;
      end
    endcase
    // Standby timer counts idle time, then spins the drive down
    if (r.tmr_en && !r.standby && r.fsm == DFP_IDLE)
    begin
      if (r.cnt == 32'h0000_0000)
      begin
        next_r.standby = 1'b1;
        next_r.spinning = 1'b0;
      end
      else
      begin
        next_r.cnt = r.cnt - 32'h0000_0001;
      end
    end
    case (r.fsm)
      DFP_IDLE:
      begin
        if (acc && pwrite && paddr == A_CMD)
        begin
          next_r.op = pwdata[CMD_OP +: 8];
          next_r.fea = pwdata[CMD_FEA +: 8];
          next_r.sc = pwdata[CMD_COUNT +: 8];
          next_r.busy = 1'b1;
          next_r.irq = 1'b0;
          next_r.err = 1'b0;
          next_r.fsm = DFP_EXEC;
        end
      end
      DFP_EXEC:
      begin
        next_r.busy = 1'b0;
        next_r.irq = 1'b1;
        next_r.fsm = DFP_IDLE;
        if (r.tmr_en)
        begin
          next_r.cnt = 32'(r.tmr_sc) * 32'(STBY_UNIT);
        end
        case (r.op)
          C_SETF:
          begin
            case (r.fea)
              F_WC_ON: next_r.wcache = 1'b1;
              F_WC_OFF: next_r.wcache = 1'b0;
              F_RLA_OFF: next_r.rla = 1'b0;
              F_RLA_ON: next_r.rla = 1'b1;
              F_PUIS_ON: next_r.puis = 1'b1;
              F_PUIS_OFF: next_r.puis = 1'b0;
              F_SPINUP:
              begin
                next_r.spinning = 1'b1;
                next_r.standby = 1'b0;
              end
              F_AAM_ON: next_r.aam = 1'b1;
              F_AAM_OFF: next_r.aam = 1'b0;
              F_LNK_ON, F_LNK_OFF:
              begin
                case (r.sc)
                  8'h02: next_r.lnk[0] = (r.fea == F_LNK_ON);
                  8'h03: next_r.lnk[1] = (r.fea == F_LNK_ON);
                  8'h06: next_r.lnk[2] = (r.fea == F_LNK_ON);
                  default: bad = 1'b1;
                endcase
              end
              F_XFER:
              begin
                // Only the mode byte is kept; the link rate is not touched
                case (r.sc[7:3])
                  X_PIO: bad = r.sc[2:1] != 2'b00;
                  X_PIOFC, X_MDMA, X_UDMA: bad = 1'b0;
                  default: bad = 1'b1;
                endcase
                if (!bad)
                begin
                  next_r.xfer = r.sc;
                end
              end
              // Obsolete and vendor codes are unsupported here
              default: bad = 1'b1;
            endcase
          end
          C_MAX, C_MAXX:
          begin
            case (r.fea)
              8'h01, 8'h02, 8'h03: bad = r.hpa_frz;
              8'h04: next_r.hpa_frz = 1'b1;
              default: bad = 1'b1;
            endcase
          end
          C_MULT:
          begin
            case (r.sc)
              8'h02, 8'h04, 8'h08, 8'h10:
              begin
                next_r.mult = r.sc[4:0];
                next_r.mult_en = 1'b1;
              end
              default:
              begin
                bad = 1'b1;
                next_r.mult_en = 1'b0;
              end
            endcase
          end
          C_SLEEP:
          begin
            next_r.standby = 1'b0;
            if (r.spinning)
            begin
              // Busy holds until the spindle has stopped
              next_r.busy = 1'b1;
              next_r.irq = 1'b0;
              next_r.cnt = 32'(SPIN_DOWN_CYC);
              next_r.fsm = DFP_SPIN;
            end
            else
            begin
              next_r.fsm = DFP_SLEEP;
            end
          end
          C_STBY:
          begin
            // Interrupt is given in the same cycle the spindle is marked stopped
            next_r.standby = 1'b1;
            next_r.spinning = 1'b0;
            next_r.tmr_en = r.sc != 8'h00;
            next_r.tmr_sc = r.sc;
            next_r.cnt = 32'(r.sc) * 32'(STBY_UNIT);
          end
          C_SMART:
          begin
            if (!r.smart && r.fea != S_ENA)
            begin
              bad = 1'b1;
            end
            else
            begin
              case (r.fea)
                S_ENA: next_r.smart = 1'b1;
                S_DIS: next_r.smart = 1'b0;
                S_ASAVE:
                begin
                  if (r.sc == 8'h00)
                  begin
                    next_r.asave = 1'b0;
                  end
                  else if (r.sc == S_AS_ON)
                  begin
                    next_r.asave = 1'b1;
                  end
                end
                S_RDATA, S_OFFL, S_RLOG, S_WLOG, S_STAT: bad = 1'b0;
                default: bad = 1'b1;
              endcase
            end
          end
          default: bad = 1'b1;
        endcase
        if (bad)
        begin
          next_r.err = 1'b1;
        end
      end
      DFP_SPIN:
      begin
        next_r.cnt = r.cnt - 32'h0000_0001;
        if (r.cnt == 32'h0000_0001)
        begin
          next_r.spinning = 1'b0;
          next_r.busy = 1'b0;
          next_r.irq = 1'b1;
          next_r.fsm = DFP_SLEEP;
        end
      end
      // Interface inactive; command writes are dropped
      DFP_SLEEP: next_r.fsm = DFP_SLEEP;
      default: next_r.fsm = DFP_IDLE;
    endcase
    // Host acknowledges the interrupt
    if (acc && pwrite && paddr == A_STAT && pwdata[ST_CLR_IRQ] && r.fsm != DFP_EXEC)
    begin
      next_r.irq = next_r.irq & (r.fsm == DFP_SPIN && r.cnt == 32'h0000_0001);
    end
    // Software reset keeps features and the multiple setting
    if (acc && pwrite && paddr == A_STAT && pwdata[ST_SRST])
    begin
      next_r.fsm = DFP_IDLE;
      next_r.busy = 1'b0;
      next_r.irq = 1'b0;
      next_r.err = 1'b0;
    end
    // Pin levels registered so no output comes from a gate
    next_r.flow_rdy = next_r.xfer != 8'h01;
    next_r.awake = next_r.fsm != DFP_SLEEP;
  end

  // ****************************************
  // Registers
  // ****************************************
  // Hard reset: multiple off, never in sleep
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.fsm <= DFP_IDLE;
      r.rla <= 1'b1;
      r.spinning <= 1'b1;
      r.xfer <= RST_XFER;
      r.mult <= RST_MULT;
      r.flow_rdy <= 1'b1;
      r.awake <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign nv_smart = r.smart;
  assign nv_asave = r.asave;
  assign busy_flag = r.busy;
  assign host_interrupt_request = r.irq;
  assign pio_flow_ready = r.flow_rdy;
  assign link_active = r.awake;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_issue(logic [7:0] c);
    acc && pwrite && paddr == A_CMD && r.fsm == DFP_IDLE && pwdata[7:0] == c;
  endsequence

  a_setf_done: assert property (@(posedge clk) disable iff (rst)
    s_issue(C_SETF) |-> ##1 busy_flag ##1 (!busy_flag && host_interrupt_request))
    else $error("set features did not finish");
  a_bad_feat_abort: assert property (@(posedge clk) disable iff (rst)
    s_issue(C_SETF) ##0 pwdata[15:8] == 8'h44 |-> ##2 r.err && $stable(r.wcache))
    else $error("obsolete feature not aborted");
  a_wcache_on: assert property (@(posedge clk) disable iff (rst)
    r.fsm == DFP_EXEC && r.op == C_SETF && r.fea == F_WC_ON |=> r.wcache)
    else $error("write cache not enabled");
  a_rla_off: assert property (@(posedge clk) disable iff (rst)
    r.fsm == DFP_EXEC && r.op == C_SETF && r.fea == F_RLA_OFF |=> !r.rla)
    else $error("look-ahead not disabled");
  a_mult_bad: assert property (@(posedge clk) disable iff (rst)
    r.fsm == DFP_EXEC && r.op == C_MULT && r.sc == 8'h03 |=> r.err && !r.mult_en)
    else $error("bad block count accepted");
  a_mult_ok: assert property (@(posedge clk) disable iff (rst)
    r.fsm == DFP_EXEC && r.op == C_MULT && r.sc == 8'h10 |=> r.mult_en && r.mult == 5'h10)
    else $error("block count not stored");
  a_sleep_spin: assert property (@(posedge clk) disable iff (rst)
    r.fsm == DFP_EXEC && r.op == C_SLEEP && r.spinning |=> busy_flag ##250
    (!busy_flag && host_interrupt_request && !link_active))
    else $error("sleep spin-down timing wrong");
  // Busy must hold through the whole spin-down, not only at its ends
  a_spin_busy: assert property (@(posedge clk) disable iff (rst)
    r.fsm == DFP_SPIN |-> busy_flag && link_active)
    else $error("busy dropped during spin-down");
  a_sleep_skip: assert property (@(posedge clk) disable iff (rst)
    r.fsm == DFP_EXEC && r.op == C_SLEEP && !r.spinning |=> !busy_flag && !link_active)
    else $error("spin-down not skipped");
  a_smart_off: assert property (@(posedge clk) disable iff (rst)
    r.fsm == DFP_EXEC && r.op == C_SMART && !r.smart && r.fea == S_DIS |=> r.err)
    else $error("disabled SMART not aborted");
  a_stby_timer: assert property (@(posedge clk) disable iff (rst)
    r.fsm == DFP_EXEC && r.op == C_STBY |=> r.tmr_en == (r.sc != 8'h00) && r.standby)
    else $error("standby timer not armed");
endmodule : dfp_cmd

// ### dfp_host.sv
`timescale 1ns/1ns
module dfp_host
(
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             stuck
);
  import dfp_pkg::*;
  // ****************************************
  // Host side of the taskfile bus
  // ****************************************
  // Bus idle at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    stuck = 1'b0;
  end
  // One transfer; released lines carry inverted junk, never stale data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 64)
    begin
      @(posedge clk);
      n++;
    end
    q = prdata;
    e = pslverr;
    stuck <= (n >= 64);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  // Command word: opcode, feature, sector count byte
  task automatic issue(input logic [7:0] op, input logic [7:0] fea, input logic [7:0] sc);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, A_CMD, {8'h00, sc, fea, op}, q, e);
  endtask : issue
  // Only way out of sleep short of a hard reset
  task automatic soft_reset();
    logic [31:0] q;
    logic        e;
    xfer(1'b1, A_STAT, 32'h0000_0100, q, e);
  endtask : soft_reset
endmodule : dfp_host

// ### drive_feature_power_command_handler_test.sv
`timescale 1ns/1ns
`define CHK(g, x) \
  begin \
    n_tests++; \
    if ((g) !== (x)) \
    begin \
      mismatches++; \
      $display("wrong value at %0t: got %h expected %h", $time, (g), (x)); \
    end \
  end
module drive_feature_power_command_handler_test;
  import dfp_pkg::*;
  // ****************************************
  // Stimulus tables
  // ****************************************
  localparam logic [31:0] FT [14] = '{32'h0200_0103, 32'h5500_0101, 32'h0600_0105,
    32'h4200_010D, 32'h1002_011D, 32'h1003_013D, 32'h1006_017D, 32'h9003_015D,
    32'hC200_0155, 32'h8600_0151, 32'hAA00_0153, 32'h8200_0152, 32'h9002_0142,
    32'h9006_0102};
  localparam logic [7:0] BADF [6] = '{8'h44, 8'hBB, 8'hD2, 8'hDF, 8'hF0, 8'hFF};
  localparam logic [15:0] XT [7] = '{16'h0100, 16'h0C02, 16'h2202, 16'h4502,
    16'h0203, 16'h1003, 16'h0002};
  localparam logic [7:0] MB [4] = '{8'h02, 8'h04, 8'h08, 8'h10};
  localparam logic [7:0] SOK [6] = '{S_RDATA, S_OFFL, S_RLOG, S_WLOG, S_STAT, S_ENA};
  localparam logic [7:0] SBAD [7] = '{S_RDATA, S_ASAVE, S_OFFL, S_RLOG, S_WLOG,
    S_DIS, S_STAT};
  localparam logic [23:0] MX [10] = '{24'hF9_0001, 24'hF9_0501, 24'hF9_FF01,
    24'hF9_0100, 24'hF9_0200, 24'hF9_0300, 24'hF9_0400, 24'hF9_0101, 24'h37_0201,
    24'h00_0001};
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, stuck;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        nv_smart_in, nv_asave_in, nv_smart, nv_asave, e;
  logic        busy_flag, host_interrupt_request, pio_flow_ready, link_active;
  logic [7:0]  xm;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cyc;
  // Standby unit shortened so the timer expires within a few dozen cycles
  dfp_cmd #(.STBY_UNIT(4)) i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .nv_smart_in(nv_smart_in), .nv_asave_in(nv_asave_in),
    .nv_smart(nv_smart), .nv_asave(nv_asave), .busy_flag(busy_flag),
    .host_interrupt_request(host_interrupt_request), .pio_flow_ready(pio_flow_ready),
    .link_active(link_active));
  dfp_host i_host (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .stuck(stuck));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic hang();
    mismatches++;
    give_verdict();
  endtask : hang
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    i_host.xfer(1'b0, a, 32'h0000_0000, q, e);
    `CHK(q & m, x)
  endtask : rdchk
  task automatic hreset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : hreset
  // Issue, poll until the interrupt shows, check error, then clear it
  task automatic cmd(input logic [7:0] op, fea, sc, input logic x);
    int  n;
    time t0;
    n = 0;
    t0 = $time;
    i_host.issue(op, fea, sc);
    do
    begin
      i_host.xfer(1'b0, A_STAT, 32'h0000_0000, q, e);
      n++;
    end
    while (q[2] !== 1'b1 && n < 200);
    cyc = int'(($time - t0) / 4);
    if (n >= 200)
      hang();
    `CHK(q[1:0], {x, 1'b0})
    i_host.xfer(1'b1, A_STAT, 32'h0000_0004, q, e);
  endtask : cmd
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_feat();
    foreach (FT[i])
    begin
      cmd(C_SETF, FT[i][31:24], FT[i][23:16], 1'b0);
      rdchk(A_FEAT, 32'h0000_03FF, {16'h0000, FT[i][15:0]});
    end
    foreach (BADF[i])
    begin
      cmd(C_SETF, BADF[i], 8'h00, 1'b1);
      rdchk(A_FEAT, 32'hFFFF_FFFF, 32'h0000_0102);
    end
  endtask : t_feat
  // Rejected modes must leave the previous byte in place
  task automatic t_xfer();
    xm = 8'h00;
    foreach (XT[i])
    begin
      cmd(C_SETF, F_XFER, XT[i][15:8], XT[i][0]);
      if (XT[i][0] == 1'b0)
        xm = XT[i][15:8];
      rdchk(A_FEAT, 32'hFF00_0000, {xm, 24'h00_0000});
      `CHK(pio_flow_ready, XT[i][1])
      `CHK(link_active, 1'b1)
    end
  endtask : t_xfer
  task automatic t_mult();
    foreach (MB[i])
    begin
      cmd(C_MULT, 8'h00, MB[i], 1'b0);
      rdchk(A_FEAT, 32'h0000_7C80, {14'h0000, MB[i], 10'h080});
    end
    cmd(C_MULT, 8'h00, 8'h03, 1'b1);
    rdchk(A_FEAT, 32'h0000_0080, 32'h0000_0000);
    cmd(C_MULT, 8'h00, 8'h08, 1'b0);
    i_host.soft_reset();
    rdchk(A_FEAT, 32'h0000_7C80, 32'h0000_2080);
    hreset(2);
    rdchk(A_FEAT, 32'hFFFF_FFFF, 32'h0000_0102);
  endtask : t_mult
  // Standby, timer expiry, sleep from both spin states
  task automatic t_power();
    cmd(C_STBY, 8'h00, 8'h00, 1'b0);
    rdchk(A_STAT, 32'h0000_003F, 32'h0000_0010);
    rdchk(A_TMR, 32'h8000_0000, 32'h0000_0000);
    cmd(C_SETF, F_SPINUP, 8'h00, 1'b0);
    rdchk(A_STAT, 32'h0000_003F, 32'h0000_0020);
    cmd(C_STBY, 8'h00, 8'h05, 1'b0);
    rdchk(A_TMR, 32'h80FF_0000, 32'h8005_0000);
    cmd(C_SETF, F_SPINUP, 8'h00, 1'b0);
    repeat (60) @(posedge clk);
    rdchk(A_STAT, 32'h0000_003F, 32'h0000_0010);
    cmd(C_SLEEP, 8'h00, 8'h00, 1'b0);
    `CHK(cyc < 250, 1'b1)
    `CHK(link_active, 1'b0)
    i_host.soft_reset();
    @(posedge clk);
    `CHK(link_active, 1'b1)
    cmd(C_STBY, 8'h00, 8'h00, 1'b0);
    cmd(C_SETF, F_SPINUP, 8'h00, 1'b0);
    cmd(C_SLEEP, 8'h00, 8'h00, 1'b0);
    `CHK(cyc >= 250, 1'b1)
    rdchk(A_STAT, 32'h0000_000F, 32'h0000_0008);
    i_host.issue(C_SETF, F_WC_ON, 8'h00);
    repeat (4) @(posedge clk);
    rdchk(A_STAT, 32'h0000_000F, 32'h0000_0008);
    rdchk(A_FEAT, 32'h0000_0001, 32'h0000_0000);
    hreset(2);
    `CHK(link_active, 1'b1)
  endtask : t_power
  // Disabled state survives a power cycle through the store
  task automatic t_smart();
    foreach (SOK[i])
      cmd(C_SMART, SOK[i], 8'h00, 1'b0);
    cmd(C_SMART, S_ASAVE, S_AS_ON, 1'b0);
    `CHK(nv_asave, 1'b1)
    cmd(C_SMART, S_ASAVE, 8'h00, 1'b0);
    `CHK(nv_asave, 1'b0)
    cmd(C_SMART, S_DIS, 8'h00, 1'b0);
    `CHK(nv_smart, 1'b0)
    nv_smart_in <= nv_smart;
    hreset(2);
    rdchk(A_FEAT, 32'h0000_0100, 32'h0000_0000);
    foreach (SBAD[i])
      cmd(C_SMART, SBAD[i], 8'h00, 1'b1);
    cmd(C_SMART, S_ENA, 8'h00, 1'b0);
    rdchk(A_FEAT, 32'h0000_0100, 32'h0000_0100);
  endtask : t_smart
  // ****************************************
  // Clock, watchdogs and main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (stuck === 1'b1)
      hang();
  initial
  begin
    repeat (100000) @(posedge clk);
    hang();
  end
  initial
  begin
    rst = 1'b1;
    nv_smart_in = 1'b1;
    nv_asave_in = 1'b0;
    hreset(10);
    rdchk(A_FEAT, 32'hFFFF_FFFF, 32'h0000_0102);
    rdchk(A_STAT, 32'h0000_003F, 32'h0000_0020);
    `CHK(nv_smart, 1'b1)
    t_feat();
    t_xfer();
    t_mult();
    t_power();
    t_smart();
    foreach (MX[i])
      cmd(MX[i][23:16], MX[i][15:8], 8'h00, MX[i][0]);
    i_host.xfer(1'b0, 8'h10, 32'h0000_0000, q, e);
    `CHK(e, 1'b1)
    give_verdict();
  end
endmodule : drive_feature_power_command_handler_test
